// [include/serial_ctl_pkg.sv]
// shared constants and types for the serial control and status link
`default_nettype none
package serial_ctl_pkg;
   // clock and timing
   localparam int CLK_HZ = 200_000_000;
   localparam int CNT_W = 32;
   localparam int STRAP_HOLD_MS = 500;
   localparam int STARTUP_MAX_S = 2;
   localparam int BLINK_MS = 20;
   localparam int FILT_MS = 50;
   localparam int STRAP_HOLD_CYC = STRAP_HOLD_MS * (CLK_HZ / 1000);
   localparam int STARTUP_CYC = STARTUP_MAX_S * CLK_HZ;
   localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
   localparam int FILT_CYC = FILT_MS * (CLK_HZ / 1000);
   localparam int STRAP_CAP_AT = 3;
   // transceiver select codes, {sel_bit0, sel_bit1}
   localparam logic [1:0] SEL_RX_ONLY = 2'h0;
   localparam logic [1:0] SEL_BOTH = 2'h1;
   localparam logic [1:0] SEL_TX_ONLY = 2'h2;
   localparam logic [1:0] SEL_NONE = 2'h3;
   // synchroniser reset values
   localparam logic [3:0] DEV_SYNC_RST = 4'hF;
   localparam logic [8:0] HOST_SYNC_RST = 9'h06F;
   // controller register map
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STAT = 4'h4;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam int CTRL_DSR = 0;
   localparam int CTRL_FLOW = 1;
   localparam int CTRL_CONN_SW = 2;
   localparam int CTRL_RXRDY = 3;
   localparam int CTRL_MODE_PD = 4;
   localparam int CTRL_XCVR = 5;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // device startup states
   typedef enum logic [2:0] {
      ST_STRAP = 3'h1,
      ST_BOOT = 3'h2,
      ST_RUN = 3'h4
   } dev_state_t;
endpackage
`default_nettype wire

// [include/serial_link_if.sv]
// pin-level link between the adapter device and its host controller
`default_nettype none
interface serial_link_if;
   logic dsr_n;
   logic dtr_n;
   logic host_rts_n;
   logic dev_rts_n;
   logic xcvr_sel_bit0;
   logic xcvr_sel_bit1;
   logic xcvr_sel_oe;
   logic conn_led_n;
   logic stat_pin_o;
   logic stat_pin_oe;
   logic stat_host_oe;
   logic stat_pin_lvl;
   logic conn_strap_oe;
   logic conn_strap_lvl;
   logic mode_pin_n;
   logic mode_host_oe;
   logic mode_pin_lvl;

   // shared wires resolved from the enables; status and connect strap pulled up, mode pin driven by the device unless the host pulls it low
   assign stat_pin_lvl = stat_pin_oe ? stat_pin_o : ~stat_host_oe;
   assign conn_strap_lvl = ~conn_strap_oe;
   assign mode_pin_lvl = mode_host_oe ? 1'b0 : mode_pin_n;

   modport dev_mp (
      input dsr_n, host_rts_n, stat_pin_lvl, conn_strap_lvl,
      output dtr_n, dev_rts_n, xcvr_sel_bit0, xcvr_sel_bit1, xcvr_sel_oe,
      output conn_led_n, stat_pin_o, stat_pin_oe, mode_pin_n
   );
   modport host_mp (
      output dsr_n, host_rts_n, stat_host_oe, conn_strap_oe, mode_host_oe,
      input dtr_n, dev_rts_n, xcvr_sel_bit0, xcvr_sel_bit1, xcvr_sel_oe,
      input conn_led_n, stat_pin_lvl, mode_pin_lvl
   );
endinterface
`default_nettype wire

// [logic/sync2.sv]
// two-flop synchroniser for a vector of pin inputs
`default_nettype none
module sync2 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;

   // first stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// [logic/adapter_dev.sv]
// adapter device end: flow control, handshake lines, straps and indicators
//
// Behaviour
// - select code chooses transmit and receive enables
// - receive enable low, transmit enable high; sel_bit1 is low for transmit only and high for none
// - select outputs driven only in transceiver mode
// - host never pulls mode pin during select
// - pause sending while peer cannot accept
// - host configures no flow control if unwired
// - DSR assertion starts a connection attempt
// - DTR asserted only when running and ready
// - connection indicator shows wireless link state
// - indicator blinks off on traffic while connected
// - connection indicator is active low
// - status pin is strap, then output
// - status output valid only after startup
// - restore strap low restores serial settings
// - both straps low restore factory settings
// - host holds restore strap steady initially
// - restore strap pulled up, open means keep
// - mode pin is indicator only
// - connect strap triggers connect when running
//
// The address map and register access over AXI4-Lite were decided locally.
`default_nettype none
module adapter_dev
   import serial_ctl_pkg::*;
#(
   parameter int STRAP_CYC = STRAP_HOLD_CYC,
   parameter int START_CYC = STARTUP_CYC,
   parameter int BLINK = BLINK_CYC
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // pins toward the host
   serial_link_if.dev_mp lnk,
   // configuration from firmware
   input wire logic cfg_xcvr_en,
   input wire logic cfg_flow_en,
   // transceiver direction requests
   input wire logic xcvr_tx_req,
   input wire logic xcvr_rx_req,
   // wireless and application status
   input wire logic link_up,
   input wire logic traffic,
   input wire logic rx_space,
   input wire logic app_ready,
   input wire logic boot_done,
   input wire logic status_ok,
   // results toward firmware
   output logic tx_allow,
   output logic connect_req,
   output logic running,
   output logic restore_serial,
   output logic restore_factory
);
   dev_state_t state_r, state_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [CNT_W-1:0] blink_r, blink_nxt;
   logic [3:0] pins_s;
   logic dsr_n_s, host_rts_n_s, stat_s, conn_strap_s;
   logic dsr_prev_r, strap_prev_r;
   logic strap_end, start_end, run;
   logic conn_edge;
   logic [1:0] sel_code;
   logic sel_oe_r, sel0_r, sel1_r;
   logic dtr_n_r, rts_n_r, led_n_r, stat_o_r, stat_oe_r, mode_n_r;
   logic conn_req_r, rst_ser_r, rst_fac_r;

   ////////////////////////////////////////////////////////////////////////
   // pin inputs

   // all host pins cross into the clock domain; all idle high, the status and connect strap via pull-ups
   sync2 #(.WIDTH(4), .RST_VAL(DEV_SYNC_RST)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({lnk.conn_strap_lvl, lnk.stat_pin_lvl, lnk.host_rts_n,
          lnk.dsr_n}),
      .q(pins_s)
   );

   // unpacked synchronised pins
   assign dsr_n_s = pins_s[0];
   assign host_rts_n_s = pins_s[1];
   assign stat_s = pins_s[2];
   assign conn_strap_s = pins_s[3];

   ////////////////////////////////////////////////////////////////////////
   // startup sequence

   // window ends and run decode
   assign strap_end = (cnt_r == CNT_W'(STRAP_CYC - 1));
   assign start_end = boot_done || (cnt_r >= CNT_W'(START_CYC - 1));
   assign run = (state_r == ST_RUN);

   // strap window, then boot for up to the startup time, then run
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         ST_STRAP: begin
            cnt_nxt = cnt_r + CNT_W'(1);
            if (strap_end) begin
               state_nxt = ST_BOOT;
            end
         end
         ST_BOOT: begin
            cnt_nxt = cnt_r + CNT_W'(1);
            if (start_end) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            cnt_nxt = cnt_r;
         end
         default: begin
            state_nxt = ST_STRAP;
            cnt_nxt = '0;
         end
      endcase
   end

   // state and window counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= ST_STRAP;
         cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // strap sample at the end of the steady window
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rst_ser_r <= 1'b0;
         rst_fac_r <= 1'b0;
      end else begin
         rst_ser_r <= (state_r == ST_STRAP) && strap_end && !stat_s
                      && conn_strap_s;
         rst_fac_r <= (state_r == ST_STRAP) && strap_end && !stat_s
                      && !conn_strap_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // connect requests

   // falling edges of DSR and of the connect strap, once running
   assign conn_edge = run && ((dsr_prev_r && !dsr_n_s)
                      || (strap_prev_r && !conn_strap_s));

   // edge history and request pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dsr_prev_r <= 1'b1;
         strap_prev_r <= 1'b1;
         conn_req_r <= 1'b0;
      end else begin
         dsr_prev_r <= dsr_n_s;
         strap_prev_r <= conn_strap_s;
         conn_req_r <= conn_edge;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flow control

   // own sending paused while the host holds its RTS high
   assign tx_allow = !cfg_flow_en || !host_rts_n_s;

   // RTS low while space remains; always low without flow control
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rts_n_r <= 1'b1;
      end else begin
         rts_n_r <= cfg_flow_en ? !rx_space : 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transceiver select

   // direction requests to select code
   always_comb begin
      case ({xcvr_tx_req, xcvr_rx_req})
         2'h0: sel_code = SEL_NONE;
         2'h1: sel_code = SEL_RX_ONLY;
         2'h2: sel_code = SEL_TX_ONLY;
         2'h3: sel_code = SEL_BOTH;
         default: sel_code = SEL_NONE;
      endcase
   end

   // outputs only enabled in transceiver mode after startup
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_oe_r <= 1'b0;
         sel0_r <= SEL_NONE[1];
         sel1_r <= SEL_NONE[0];
      end else begin
         sel_oe_r <= cfg_xcvr_en && run;
         sel0_r <= (cfg_xcvr_en && run) ? sel_code[1] : SEL_NONE[1];
         sel1_r <= (cfg_xcvr_en && run) ? sel_code[0] : SEL_NONE[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // indicators and ready line

   // blink timer restarted by each traffic pulse while the link is up
   always_comb begin
      blink_nxt = blink_r;
      if (traffic && link_up) begin
         blink_nxt = CNT_W'(BLINK);
      end else if (blink_r != '0) begin
         blink_nxt = blink_r - CNT_W'(1);
      end
   end

   // indicator registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         blink_r <= '0;
         led_n_r <= 1'b1;
         dtr_n_r <= 1'b1;
         stat_o_r <= 1'b1;
         stat_oe_r <= 1'b0;
         mode_n_r <= 1'b0;
      end else begin
         blink_r <= blink_nxt;
         led_n_r <= !(link_up && (blink_r == '0));
         dtr_n_r <= !(run && app_ready);
         stat_o_r <= !status_ok;
         stat_oe_r <= run;
         mode_n_r <= run;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   // pins toward the host
   assign lnk.dtr_n = dtr_n_r;
   assign lnk.dev_rts_n = rts_n_r;
   assign lnk.xcvr_sel_bit0 = sel0_r;
   assign lnk.xcvr_sel_bit1 = sel1_r;
   assign lnk.xcvr_sel_oe = sel_oe_r;
   assign lnk.conn_led_n = led_n_r;
   assign lnk.stat_pin_o = stat_o_r;
   assign lnk.stat_pin_oe = stat_oe_r;
   assign lnk.mode_pin_n = mode_n_r;

   // results toward firmware
   assign connect_req = conn_req_r;
   assign running = run;
   assign restore_serial = rst_ser_r;
   assign restore_factory = rst_fac_r;
endmodule
`default_nettype wire

// [logic/adapter_host.sv]
// host controller end: register-driven pins toward the adapter
`default_nettype none
module adapter_host
   import serial_ctl_pkg::*;
#(
   parameter int HOLD_CYC = STRAP_HOLD_CYC,
   parameter int FILT = FILT_CYC
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pins toward the adapter
   serial_link_if.host_mp lnk,
   // board strap requests and local flow gate
   input wire logic strap_restore,
   input wire logic strap_factory,
   output logic tx_allow
);
   logic [8:0] pins_s;
   logic dtr_s, rts_s, led_s, stat_s, sel_oe_s, sel0_s, sel1_s;
   logic req_rst_s, req_fac_s;
   logic [7:0] ctrl_r;
   logic [CNT_W-1:0] hold_r, filt_r;
   logic hold, cap_rst_r, cap_fac_r, conn_r;
   logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [7:0] wbyte_r;
   logic wstrb0_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic do_write, wr_ctrl, rd_ok;
   logic [7:0] stat_word;

   ////////////////////////////////////////////////////////////////////////
   // pin inputs

   // adapter pins and board switches cross into the clock domain
   sync2 #(.WIDTH(9), .RST_VAL(HOST_SYNC_RST)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({strap_factory, strap_restore, lnk.xcvr_sel_bit1,
          lnk.xcvr_sel_bit0, lnk.xcvr_sel_oe, lnk.stat_pin_lvl,
          lnk.conn_led_n, lnk.dev_rts_n, lnk.dtr_n}),
      .q(pins_s)
   );

   // unpacked synchronised inputs
   assign dtr_s = pins_s[0];
   assign rts_s = pins_s[1];
   assign led_s = pins_s[2];
   assign stat_s = pins_s[3];
   assign sel_oe_s = pins_s[4];
   assign sel0_s = pins_s[5];
   assign sel1_s = pins_s[6];
   assign req_rst_s = pins_s[7];
   assign req_fac_s = pins_s[8];

   ////////////////////////////////////////////////////////////////////////
   // strap hold after reset

   // straps latched once after release and held through the window
   assign hold = (hold_r < CNT_W'(HOLD_CYC));

   // hold counter and captured straps
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_r <= '0;
         cap_rst_r <= 1'b0;
         cap_fac_r <= 1'b0;
      end else begin
         if (hold) begin
            hold_r <= hold_r + CNT_W'(1);
         end
         if (hold_r == CNT_W'(STRAP_CAP_AT)) begin
            cap_rst_r <= req_rst_s;
            cap_fac_r <= req_fac_s && req_rst_s;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // connection filter

   // steady connected level from the blinking indicator
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         filt_r <= '0;
         conn_r <= 1'b0;
      end else if (!led_s) begin
         filt_r <= CNT_W'(FILT);
         conn_r <= 1'b1;
      end else if (filt_r != '0) begin
         filt_r <= filt_r - CNT_W'(1);
      end else begin
         conn_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite slave

   // handshakes and decode
   assign s_axi_awready = !aw_got_r && !bvalid_r;
   assign s_axi_wready = !w_got_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign do_write = aw_got_r && w_got_r && !bvalid_r;
   assign wr_ctrl = do_write && (awaddr_r == REG_CTRL) && wstrb0_r;
   assign rd_ok = (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_STAT);
   assign stat_word = {hold, tx_allow, sel_oe_s, sel1_s, sel0_s, stat_s,
                       conn_r, !dtr_s};

   // write path: address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         awaddr_r <= '0;
         wbyte_r <= '0;
         wstrb0_r <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wbyte_r <= s_axi_wdata[7:0];
            wstrb0_r <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= ((awaddr_r == REG_CTRL) || (awaddr_r == REG_STAT))
                       ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= wbyte_r;
      end
   end

   // read path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         rdata_r <= (s_axi_araddr == REG_CTRL) ? {24'h000000, ctrl_r}
                    : (s_axi_araddr == REG_STAT) ? {24'h000000, stat_word}
                    : 32'h00000000;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // bus outputs
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   ////////////////////////////////////////////////////////////////////////
   // pins toward the adapter

   // flow gate on the adapter RTS; ignored when flow control is off
   assign tx_allow = !ctrl_r[CTRL_FLOW] || !rts_s;
   assign lnk.dsr_n = !ctrl_r[CTRL_DSR];
   assign lnk.host_rts_n = !ctrl_r[CTRL_RXRDY];
   assign lnk.stat_host_oe = hold && cap_rst_r;
   assign lnk.conn_strap_oe = hold ? cap_fac_r
                              : ctrl_r[CTRL_CONN_SW];
   assign lnk.mode_host_oe = ctrl_r[CTRL_MODE_PD] && !ctrl_r[CTRL_XCVR]
                             && !sel_oe_s;
endmodule
`default_nettype wire

// [tb/serial_host_control_status_assertions.sv]
// concurrent checks on the device end of the serial link
`default_nettype none
module serial_host_control_status_assertions (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // link pins
   input wire logic dsr_n,
   input wire logic dtr_n,
   input wire logic dev_rts_n,
   input wire logic xcvr_sel_bit0,
   input wire logic xcvr_sel_bit1,
   input wire logic xcvr_sel_oe,
   input wire logic conn_led_n,
   input wire logic stat_pin_oe,
   // device side
   input wire logic cfg_xcvr_en,
   input wire logic cfg_flow_en,
   input wire logic xcvr_tx_req,
   input wire logic xcvr_rx_req,
   input wire logic link_up,
   input wire logic traffic,
   input wire logic rx_space,
   input wire logic running,
   input wire logic connect_req
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////
   // select lines, indicators and handshake lines
   property p_sel_code;
      xcvr_sel_oe |-> xcvr_sel_bit0 == !$past(xcvr_rx_req) &&
         xcvr_sel_bit1 == ($past(xcvr_tx_req) == $past(xcvr_rx_req));
   endproperty
   a_sel_code: assert property (p_sel_code)
      else $error("select code");
   property p_sel_gate;
      xcvr_sel_oe |-> $past(cfg_xcvr_en && running);
   endproperty
   a_sel_gate: assert property (p_sel_gate)
      else $error("select outside mode");
   property p_led_idle;
      !link_up |=> conn_led_n;
   endproperty
   a_led_idle: assert property (p_led_idle)
      else $error("indicator lit unlinked");
   property p_led_blink;
      link_up && traffic |-> ##2 conn_led_n [*4];
   endproperty
   a_led_blink: assert property (p_led_blink)
      else $error("no blink");
   property p_dtr_ready;
      !dtr_n |-> $past(running);
   endproperty
   a_dtr_ready: assert property (p_dtr_ready)
      else $error("ready too early");
   property p_stat_late;
      stat_pin_oe |-> $past(running);
   endproperty
   a_stat_late: assert property (p_stat_late)
      else $error("status driven early");
   property p_rts;
      $past(aresetn) |-> dev_rts_n == $past(cfg_flow_en && !rx_space);
   endproperty
   a_rts: assert property (p_rts)
      else $error("rts level");
   property p_connect;
      running && $fell(dsr_n) |-> ##[1:5] connect_req;
   endproperty
   a_connect: assert property (p_connect)
      else $error("no connect");
endmodule
`default_nettype wire

// [tb/serial_host_control_status_test.sv]
// bench for the adapter device and host controller pair
`default_nettype none
module serial_host_control_status_test
   import serial_ctl_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [ADDR_W-1:0] awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
   logic bready = 1'h1, rready = 1'h1, boot = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic cfg_xcvr_en = 1'h0, cfg_flow_en = 1'h0, app_ready = 1'h1;
   logic tx_req = 1'h0, rx_req = 1'h0, link_up = 1'h0, traffic = 1'h0;
   logic rx_space = 1'h0, status_ok = 1'h0, s_rst = 1'h0, s_fac = 1'h0;
   logic d_tx, h_tx, conn_req, running, rs_pls, rf_pls;
   logic [2:0] sel;
   int num_errors = 0, total_checks = 0, n_conn = 0, n_rs = 0, n_rf = 0;
   serial_link_if lnk_if ();
   assign sel = {lnk_if.xcvr_sel_bit0, lnk_if.xcvr_sel_bit1,
      lnk_if.xcvr_sel_oe};
   ////////////////////////////////////////////////////////////////////////
   // both ends and the checker, counts shortened
   adapter_dev #(.STRAP_CYC(20), .START_CYC(60), .BLINK(5)) adapter_dev_i (
      .aclk(aclk), .aresetn(aresetn), .lnk(lnk_if.dev_mp),
      .cfg_xcvr_en(cfg_xcvr_en), .cfg_flow_en(cfg_flow_en),
      .xcvr_tx_req(tx_req), .xcvr_rx_req(rx_req), .link_up(link_up),
      .traffic(traffic), .rx_space(rx_space), .app_ready(app_ready),
      .boot_done(boot), .status_ok(status_ok), .tx_allow(d_tx),
      .connect_req(conn_req), .running(running),
      .restore_serial(rs_pls), .restore_factory(rf_pls));
   adapter_host #(.HOLD_CYC(40), .FILT(10)) adapter_host_i (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(sel), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(sel),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .lnk(lnk_if.host_mp),
      .strap_restore(s_rst), .strap_factory(s_fac), .tx_allow(h_tx));
   serial_host_control_status_assertions chk_i (
      .aclk(aclk), .aresetn(aresetn), .dsr_n(lnk_if.dsr_n),
      .dtr_n(lnk_if.dtr_n), .dev_rts_n(lnk_if.dev_rts_n),
      .xcvr_sel_bit0(lnk_if.xcvr_sel_bit0),
      .xcvr_sel_bit1(lnk_if.xcvr_sel_bit1),
      .xcvr_sel_oe(lnk_if.xcvr_sel_oe), .conn_led_n(lnk_if.conn_led_n),
      .stat_pin_oe(lnk_if.stat_pin_oe), .cfg_xcvr_en(cfg_xcvr_en),
      .cfg_flow_en(cfg_flow_en), .xcvr_tx_req(tx_req), .xcvr_rx_req(rx_req),
      .link_up(link_up), .traffic(traffic), .rx_space(rx_space),
      .running(running), .connect_req(conn_req));
   ////////////////////////////////////////////////////////////////////////
   // clock and pulse counters
   initial forever #2.5 aclk = ~aclk;
   always @(posedge aclk) begin
      n_conn <= n_conn + int'(conn_req === 1'h1);
      n_rs <= n_rs + int'(rs_pls === 1'h1);
      n_rf <= n_rf + int'(rf_pls === 1'h1);
   end
   ////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic chk(input logic [31:0] got, exp, input string what);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %h", $time, what, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] st, output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      wstrb <= st;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid) begin
            r = bresp;
            break;
         end
      end
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d,
      output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'h1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            break;
         end
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // watchdog against a hung handshake
   initial begin
      tick(6000);
      num_errors++;
      final_report();
   end
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [31:0] v, w;
      logic [1:0] r;
      logic [3:0] f;
      v = $urandom(32'h1A4CE6FA);
      // startups: keep, serial restore, factory restore
      for (int k = 0; k < 3; k++) begin
         aresetn <= 1'h0;
         s_rst <= 1'(k > 0);
         s_fac <= 1'(k == 2);
         boot <= 1'(k == 1);
         tick(20);
         aresetn <= 1'h1;
         tick(10);
         chk(lnk_if.stat_pin_oe, 0, "status early");
         tick(15);
         chk(running, k == 1, "early boot");
         tick(75);
         chk(n_rs, k > 0, "serial restore");
         chk(n_rf, k == 2, "factory restore");
         chk({running, lnk_if.dtr_n, lnk_if.stat_pin_oe}, 5, "run");
      end
      // register map, refusals and byte strobe
      rd_reg(REG_CTRL, v, r);
      chk(v, CTRL_RST, "ctrl reset");
      rd_reg(4'h8, v, r);
      chk({v[29:0], r}, RESP_SLVERR, "unmapped read");
      wr(4'hC, 32'hFF, 4'hF, r);
      chk(r, RESP_SLVERR, "unmapped write");
      wr(REG_STAT, 32'hFF, 4'hF, r);
      chk(r, RESP_OKAY, "status write");
      w = $urandom & 32'hFFFFFFFA;
      wr(REG_CTRL, w, 4'hF, r);
      wr(REG_CTRL, ~w, 4'hE, r);
      rd_reg(REG_CTRL, v, r);
      chk(v, w & 32'hFA, "ctrl store");
      // flow gates on both ends, first case all blocked
      for (int i = 0; i < 16; i++) begin
         f = (i == 0) ? 4'h5 : 4'($urandom);
         cfg_flow_en <= f[0];
         rx_space <= f[1];
         wr(REG_CTRL, {28'h0, f[3], 1'h0, f[2], 1'h0}, 4'hF, r);
         tick(6);
         chk(d_tx, !f[0] || f[3], "device gate");
         chk(h_tx, !f[2] || !f[0] || f[1], "host gate");
      end
      // select codes with the mode pull-down requested
      wr(REG_CTRL, 32'h10, 4'hF, r);
      cfg_xcvr_en <= 1'h1;
      for (int i = 0; i < 10; i++) begin
         f = (i < 4) ? 4'(i) : 4'($urandom);
         tx_req <= f[1];
         rx_req <= f[0];
         tick(6);
         chk(sel, {!f[0], f[1] == f[0], 1'h1}, "select");
         chk(lnk_if.mode_host_oe, 0, "mode pull");
      end
      cfg_xcvr_en <= 1'h0;
      tick(6);
      chk(sel, 3'h6, "select idle");
      chk(lnk_if.mode_host_oe, 1, "mode idle");
      // connect from request line, then from the switch strap
      wr(REG_CTRL, 32'h1, 4'hF, r);
      tick(8);
      chk(n_conn, 1, "request connect");
      wr(REG_CTRL, 32'h4, 4'hF, r);
      tick(8);
      chk(n_conn, 2, "switch connect");
      // indicator, traffic blanking and status pin
      link_up <= 1'h1;
      repeat (30) begin
         traffic <= 1'($urandom);
         status_ok <= 1'($urandom);
         tick(1);
      end
      traffic <= 1'h0;
      tick(10);
      chk(lnk_if.conn_led_n, 0, "linked");
      chk(lnk_if.stat_pin_lvl, !status_ok, "status pin");
      traffic <= 1'h1;
      tick(1);
      traffic <= 1'h0;
      tick(3);
      chk(lnk_if.conn_led_n, 1, "blink");
      link_up <= 1'h0;
      tick(12);
      chk(lnk_if.conn_led_n, 1, "unlinked");
      final_report();
   end
endmodule
`default_nettype wire
